//--- rtl/sec_lock_state.sv
// Security lock state machine of a drive command layer, with its task file
// style registers reached over AXI4-Lite.
// Assumes software loads control word and password before writing a command.
//
// Behaviour
// R1: Disable-password with matching selected password leaves lock mode.
// R2: Disable-password never alters the stored Master password.
// R3: Control word bit 0 picks User or Master; 32-byte password follows.
// R4: Host issues erase-prepare right before every erase-unit.
// R5: Erase-unit with wrong password is aborted.
// R6: Erase-unit not directly after erase-prepare is aborted.
// R7: Frozen state rejects set, unlock, disable and erase commands.
// R8: Frozen state clears only on power-on or hardware reset.
// R9: Freeze lock while frozen completes normally, stays frozen.
// R10: Completed freeze lock zeroes the sector count register.
// R11: Without security support the freeze opcode runs wear levelling.
// R12: Set User at High stores it, locks next reset, both passwords unlock.
// R13: Set User at Maximum: only User password unlocks; Master kept.
// R14: Set Master stores Master only; lock mode and level unchanged.
// R15: Master unlock at High level compares against stored Master password.
// R16: Master unlock at Maximum level is rejected.
// R17: User unlock compares against stored User password.
// R18: Failed unlock while locked aborts and decrements counter from five.
// R19: Counter at zero aborts every unlock and erase until reset.
// R20: Unlock while unlocked leaves the counter unchanged.
// R21: Identify word 128 bit 5 reports enhanced erase support.
// R22: Set-password control word bit 8 selects High or Maximum level.
// R23: Aborts show as error flag plus command completion.
//
// The address map and the AXI4-Lite register port were decided locally.
`default_nettype none

module sec_lock_state
    import sec_lock_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // AXI4-Lite write address and data
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Command events
    output logic                   cmd_done,
    output logic                   cmd_abort,
    output logic                   erase_start,
    output logic                   wear_level_start
);

    ////////////////////////////////////////////////////////////////////////
    // State
    logic                   awready_q;
    logic                   wready_q;
    logic                   bvalid_q;
    logic [1:0]             bresp_q;
    logic                   arready_q;
    logic                   rvalid_q;
    logic [1:0]             rresp_q;
    logic [31:0]            rdata_q;
    logic [ADDR_W-1:0]      araddr_q;
    logic [15:0]            ctrl_q;
    logic [7:0]             seccnt_q;
    logic                   support_q;
    logic [PW_WORDS-1:0][31:0] pw_q;
    logic [PW_WORDS-1:0][31:0] user_pw_q;
    logic [PW_WORDS-1:0][31:0] master_pw_q;
    logic                   enabled_q;
    logic                   locked_q;
    logic                   level_max_q;
    logic                   frozen_q;
    logic                   prep_q;
    logic [2:0]             tries_q;
    logic                   done_q;
    logic                   err_q;
    logic                   done_pulse_q;
    logic                   abort_pulse_q;
    logic                   erase_q;
    logic                   wear_q;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire                    wr_fire   = awready_q & wready_q;
    wire                    wr_take   = s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
    wire                    rd_take   = s_axi_arvalid & ~arready_q & ~rvalid_q;
    wire [ADDR_W-1:0]       waddr     = s_axi_awaddr;
    wire                    wr_cmd    = wr_fire & (waddr == OFF_CMD);
    wire                    wr_ctrlw  = wr_fire & (waddr == OFF_CTRLW);
    wire                    wr_seccnt = wr_fire & (waddr == OFF_SECCNT);
    wire                    wr_config = wr_fire & (waddr == OFF_CONFIG);
    wire                    wr_hwrst  = wr_fire & (waddr == OFF_HWRST);
    wire                    wr_pw     = wr_fire & (waddr >= OFF_PW0) & (waddr[1:0] == 2'h0)
                                        & (waddr < OFF_PW0 + 8'(PW_WORDS * 4));
    wire [2:0]              pw_idx    = waddr[4:2];
    wire                    w_mapped  = wr_cmd | wr_ctrlw | wr_seccnt | wr_config | wr_hwrst | wr_pw;
    wire [31:0]             wmask     = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                         {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

    ////////////////////////////////////////////////////////////////////////
    // Command evaluation, all in the cycle the command word is taken
    wire [7:0]              op         = s_axi_wdata[7:0];
    wire                    op_set     = wr_cmd & (op == OP_SET_PW);
    wire                    op_unlock  = wr_cmd & (op == OP_UNLOCK);
    wire                    op_prep    = wr_cmd & (op == OP_PREPARE);
    wire                    op_erase   = wr_cmd & (op == OP_ERASE);
    wire                    op_freeze  = wr_cmd & (op == OP_FREEZE);
    wire                    op_disable = wr_cmd & (op == OP_DISABLE);
    wire                    id_master  = ctrl_q[CW_ID_BIT];       // R3
    wire                    want_max   = ctrl_q[CW_LEVEL_BIT];    // R22
    wire                    user_match = (pw_q == user_pw_q);     // R17
    wire                    mstr_match = (pw_q == master_pw_q);   // R15
    wire                    sel_match  = id_master ? mstr_match : user_match;
    wire                    expired    = (tries_q == 3'h0);
    wire                    mstr_refuse = id_master & level_max_q; // R16
    wire                    gated      = frozen_q | ~support_q;   // R7

    // Abort decision per opcode; unknown opcodes are refused as well
    logic                   abort_c;
    always_comb
    begin
        abort_c = 1'b0;
        case (op)
            OP_SET_PW:  abort_c = gated | locked_q;
            OP_UNLOCK:  abort_c = gated | expired | mstr_refuse | ~sel_match;      // R19
            OP_PREPARE: abort_c = ~support_q;
            OP_ERASE:   abort_c = gated | expired | ~prep_q | ~sel_match;          // R5 R6
            OP_FREEZE:  abort_c = 1'b0;                                            // R9 R11
            OP_DISABLE: abort_c = gated | (id_master & level_max_q) | ~sel_match;
            default:    abort_c = 1'b1;
        endcase
    end

    wire                    ok_cmd     = wr_cmd & ~abort_c;
    // Mismatch counts only while locked and not already refused outright
    wire                    try_fail   = op_unlock & locked_q & ~gated & ~expired
                                         & ~mstr_refuse & ~sel_match;             // R18 R20
    wire                    freeze_ok  = op_freeze & support_q;
    wire                    set_user   = op_set & ok_cmd & ~id_master;            // R12 R13
    wire                    set_master = op_set & ok_cmd & id_master;             // R14
    wire                    unlock_ok  = (op_unlock | op_disable | op_erase) & ok_cmd;

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data are taken together, response follows
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end
        else
        begin
            awready_q <= wr_take;
            wready_q  <= wr_take;
            if (wr_fire)
            begin
                bvalid_q <= 1'b1;
                bresp_q  <= w_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel
    wire [31:0] status_w = {16'h0, 5'h0, tries_q, 1'b0, prep_q, level_max_q, enabled_q,
                            locked_q, frozen_q, err_q, done_q};                   // R23
    wire [31:0] ident_w  = (32'h1 << IDW_ENHANCED)                                // R21
                         | (32'(support_q)   << IDW_SUPPORT)
                         | (32'(enabled_q)   << IDW_ENABLED)
                         | (32'(locked_q)    << IDW_LOCKED)
                         | (32'(frozen_q)    << IDW_FROZEN)
                         | (32'(expired)     << IDW_EXPIRED)
                         | (32'(level_max_q) << IDW_MAXLVL);
    wire        r_pw     = (araddr_q >= OFF_PW0) & (araddr_q[1:0] == 2'h0)
                           & (araddr_q < OFF_PW0 + 8'(PW_WORDS * 4));
    wire        r_mapped = r_pw | (araddr_q == OFF_CMD) | (araddr_q == OFF_STATUS)
                           | (araddr_q == OFF_CTRLW) | (araddr_q == OFF_SECCNT)
                           | (araddr_q == OFF_CONFIG) | (araddr_q == OFF_HWRST)
                           | (araddr_q == OFF_IDENT);
    wire [31:0] rd_mux   = r_pw                     ? pw_q[araddr_q[4:2]] :
                           (araddr_q == OFF_STATUS) ? status_w :
                           (araddr_q == OFF_CTRLW)  ? {16'h0, ctrl_q} :
                           (araddr_q == OFF_SECCNT) ? {24'h0, seccnt_q} :
                           (araddr_q == OFF_CONFIG) ? {31'h0, support_q} :
                           (araddr_q == OFF_IDENT)  ? ident_w : 32'h0;

    // Address is latched with arready, data presented the cycle after
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= 32'h0;
            araddr_q  <= '0;
        end
        else
        begin
            arready_q <= rd_take;
            if (rd_take)
                araddr_q <= s_axi_araddr;
            if (arready_q)
            begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_mux;
                rresp_q  <= r_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rready)
                rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Parameter sector image: control word and password words
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctrl_q    <= 16'h0;
            support_q <= CFG_SUPPORT_RST;
            pw_q      <= '0;
        end
        else
        begin
            if (wr_ctrlw)
                ctrl_q <= (ctrl_q & ~wmask[15:0]) | (s_axi_wdata[15:0] & wmask[15:0]);
            if (wr_config & s_axi_wstrb[0])
                support_q <= s_axi_wdata[0];
            if (wr_pw)
                pw_q[pw_idx] <= (pw_q[pw_idx] & ~wmask) | (s_axi_wdata & wmask);
        end
    end

    // Sector count: software writable, cleared by a completed freeze lock
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            seccnt_q <= 8'h0;
        else if (freeze_ok)
            seccnt_q <= 8'h0;                                                     // R10
        else if (wr_seccnt & s_axi_wstrb[0])
            seccnt_q <= s_axi_wdata[7:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Stored passwords and security level; these model non-volatile state,
    // so only sys_rst (power-on) clears them, never the hardware reset
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            user_pw_q   <= '0;
            master_pw_q <= '0;
            enabled_q   <= 1'b0;
            level_max_q <= 1'b0;
        end
        else
        begin
            if (set_user)
            begin
                user_pw_q   <= pw_q;                                              // R12
                enabled_q   <= 1'b1;
                level_max_q <= want_max;                                          // R13 R22
            end
            if (set_master)
                master_pw_q <= pw_q;                                              // R14
            // Disable and erase drop lock mode; the Master password stays
            if ((op_disable | op_erase) & ok_cmd)
                enabled_q <= 1'b0;                                                // R1 R2
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Volatile lock state; hardware reset relocks an enabled drive
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            locked_q <= 1'b0;
            frozen_q <= 1'b0;
            prep_q   <= 1'b0;
            tries_q  <= UNLOCK_TRIES;
        end
        else if (wr_hwrst)
        begin
            locked_q <= enabled_q;                                                // R12
            frozen_q <= 1'b0;                                                     // R8
            prep_q   <= 1'b0;
            tries_q  <= UNLOCK_TRIES;                                             // R19
        end
        else
        begin
            if (unlock_ok)
                locked_q <= 1'b0;                                                 // R1 R15 R17
            if (freeze_ok)
                frozen_q <= 1'b1;                                                 // R7 R9
            if (wr_cmd)
                prep_q <= op_prep & ~abort_c;                                     // R4 R6
            if (try_fail)
                tries_q <= tries_q - 3'h1;                                        // R18
        end
    end

    // Completion events and status flags; a new command clears the old result
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            done_q        <= 1'b0;
            err_q         <= 1'b0;
            done_pulse_q  <= 1'b0;
            abort_pulse_q <= 1'b0;
            erase_q       <= 1'b0;
            wear_q        <= 1'b0;
        end
        else
        begin
            done_pulse_q  <= wr_cmd;
            abort_pulse_q <= wr_cmd & abort_c;                                    // R23
            erase_q       <= op_erase & ~abort_c;
            wear_q        <= op_freeze & ~support_q;                              // R11
            if (wr_cmd)
            begin
                done_q <= 1'b1;
                err_q  <= abort_c;                                                // R23
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign s_axi_awready    = awready_q;
    assign s_axi_wready     = wready_q;
    assign s_axi_bvalid     = bvalid_q;
    assign s_axi_bresp      = bresp_q;
    assign s_axi_arready    = arready_q;
    assign s_axi_rvalid     = rvalid_q;
    assign s_axi_rdata      = rdata_q;
    assign s_axi_rresp      = rresp_q;
    assign cmd_done         = done_pulse_q;
    assign cmd_abort        = abort_pulse_q;
    assign erase_start      = erase_q;
    assign wear_level_start = wear_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_FROZEN_STICKY: assert property (frozen_q && !wr_hwrst |=> frozen_q)       // R8
        else $error("frozen state left without reset");
    AST_FROZEN_REJECT: assert property (frozen_q && (op_set || op_unlock || op_disable || op_erase)
        |=> cmd_abort && cmd_done && err_q)                                      // R7
        else $error("command accepted while frozen");
    AST_FREEZE_ZERO: assert property (freeze_ok |=> seccnt_q == 8'h0 && frozen_q && !cmd_abort) // R10
        else $error("freeze lock did not clear sector count");
    AST_WEAR_LEVEL: assert property (op_freeze && !support_q |=> wear_level_start && $stable(frozen_q)) // R11
        else $error("unsupported freeze did not start wear levelling");
    AST_ERASE_PREP: assert property (op_erase && !prep_q |=> cmd_abort && !erase_start) // R6
        else $error("erase without prepare was not aborted");
    AST_ERASE_PW: assert property (op_erase && !sel_match |=> cmd_abort && !erase_start) // R5
        else $error("erase with wrong password was not aborted");
    AST_TRIES_DEC: assert property (op_unlock && locked_q && !frozen_q && support_q && tries_q != 3'h0
        && !mstr_refuse && !sel_match |=> tries_q == $past(tries_q) - 3'h1 && cmd_abort) // R18
        else $error("failed unlock did not decrement counter");
    AST_TRIES_EXPIRED: assert property (tries_q == 3'h0 && (op_unlock || op_erase)
        |=> cmd_abort && $stable(locked_q))                                      // R19
        else $error("command accepted with counter at zero");
    AST_UNLOCKED_TRIES: assert property (op_unlock && !locked_q |=> $stable(tries_q)) // R20
        else $error("unlock while unlocked changed counter");
    AST_MASTER_MAX: assert property (op_unlock && id_master && level_max_q
        |=> cmd_abort && $stable(locked_q))                                      // R16
        else $error("master unlock accepted at maximum level");
    AST_DISABLE_MASTER: assert property (op_disable |=> $stable(master_pw_q))    // R2
        else $error("disable changed the master password");
    AST_SET_MASTER: assert property (set_master |=> master_pw_q == $past(pw_q)
        && $stable(enabled_q) && $stable(level_max_q))                           // R14
        else $error("master set changed lock mode or level");

endmodule

`default_nettype wire

//--- shared/sec_lock_pkg.sv
// Constants for the drive security lock state block: opcodes, register map,
// control word fields, status layout and reset values.
// Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
`default_nettype none

package sec_lock_pkg;

    // Security command opcodes
    localparam logic [7:0] OP_SET_PW  = 8'hF1;
    localparam logic [7:0] OP_UNLOCK  = 8'hF2;
    localparam logic [7:0] OP_PREPARE = 8'hF3;
    localparam logic [7:0] OP_ERASE   = 8'hF4;
    localparam logic [7:0] OP_FREEZE  = 8'hF5;
    localparam logic [7:0] OP_DISABLE = 8'hF6;

    // Register byte offsets
    localparam int         ADDR_W     = 8;
    localparam logic [7:0] OFF_CMD    = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_CTRLW  = 8'h08;
    localparam logic [7:0] OFF_SECCNT = 8'h0C;
    localparam logic [7:0] OFF_CONFIG = 8'h10;
    localparam logic [7:0] OFF_HWRST  = 8'h14;
    localparam logic [7:0] OFF_IDENT  = 8'h18;
    localparam logic [7:0] OFF_PW0    = 8'h20;
    localparam int         PW_WORDS   = 8;

    // Control word fields (word 0 of the parameter sector)
    localparam int CW_ID_BIT    = 0;
    localparam int CW_LEVEL_BIT = 8;

    // Status register fields
    localparam int ST_DONE    = 0;
    localparam int ST_ERR     = 1;
    localparam int ST_FROZEN  = 2;
    localparam int ST_LOCKED  = 3;
    localparam int ST_ENABLED = 4;
    localparam int ST_MAXLVL  = 5;
    localparam int ST_PREP    = 6;
    localparam int ST_TRIES   = 8;

    // Identify word 128 fields
    localparam int IDW_SUPPORT  = 0;
    localparam int IDW_ENABLED  = 1;
    localparam int IDW_LOCKED   = 2;
    localparam int IDW_FROZEN   = 3;
    localparam int IDW_EXPIRED  = 4;
    localparam int IDW_ENHANCED = 5;
    localparam int IDW_MAXLVL   = 8;

    // Reset values and counts
    localparam logic [2:0]  UNLOCK_TRIES    = 3'h5;
    localparam logic        CFG_SUPPORT_RST = 1'b1;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage

`default_nettype wire

//--- bench/host_port.sv
// Host model: AXI4-Lite master carrying register traffic and commands.
// Assumes it shares the device clock and that every answer comes in time.
`default_nettype none
module host_port
    import sec_lock_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Write address, data and response
    output logic [ADDR_W-1:0]      s_axi_awaddr,
    output logic                   s_axi_awvalid,
    input  wire logic              s_axi_awready,
    output logic [31:0]            s_axi_wdata,
    output logic [3:0]             s_axi_wstrb,
    output logic                   s_axi_wvalid,
    input  wire logic              s_axi_wready,
    input  wire logic              s_axi_bvalid,
    input  wire logic [1:0]        s_axi_bresp,
    output logic                   s_axi_bready,
    // Read
    output logic [ADDR_W-1:0]      s_axi_araddr,
    output logic                   s_axi_arvalid,
    input  wire logic              s_axi_arready,
    input  wire logic [31:0]       s_axi_rdata,
    input  wire logic [1:0]        s_axi_rresp,
    input  wire logic              s_axi_rvalid,
    output logic                   s_axi_rready,
    // Command events: done, abort, erase, wear level
    input  wire logic [3:0]        ev
);
////////////////////////////////////////////////////////////////////////////////
// Response code of the last write
logic [1:0] br;
// Idle bus; ready lines stay high so every answer is taken at once
initial
begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
end
// Write one word; e holds the command events seen with the response
task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [3:0] e);
    logic ok_a;
    logic ok_w;
    ok_a = 1'b0;
    ok_w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ok_a && ok_w))
    begin
        @(posedge clk);
        ok_a = ok_a | s_axi_awready;
        ok_w = ok_w | s_axi_wready;
        if (ok_a) s_axi_awvalid <= 1'b0;
        if (ok_w) s_axi_wvalid <= 1'b0;
    end
    // Released lines show the inverse so a stale value cannot pass
    s_axi_awaddr <= ~a;
    s_axi_wdata <= ~d;
    do @(posedge clk); while (!s_axi_bvalid);
    e = ev;
    br = s_axi_bresp;
endtask
// Read one word with its response code
task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
// Bench for the security lock block: command sequences through the host
// model, checking events and status. Assumes package and host model first.
`default_nettype none
module tb
    import sec_lock_pkg::*;
;
timeunit 1ns;
timeprecision 1ps;
logic clk;
logic sys_rst;
wire logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
wire logic [31:0] s_axi_wdata, s_axi_rdata;
wire logic [3:0] s_axi_wstrb;
wire logic [1:0] s_axi_rresp, s_axi_bresp;
wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
wire logic cmd_done, cmd_abort, erase_start, wear_level_start;
int errors;
int cmp_count;
logic [31:0] rv;
logic [1:0] rr;
logic [3:0] ev;
logic [7:0] ops [4] = '{OP_ERASE, OP_SET_PW, OP_UNLOCK, OP_DISABLE};
////////////////////////////////////////////////////////////////////////////////
sec_lock_state dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cmd_done, .cmd_abort, .erase_start, .wear_level_start);
host_port host (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ev({cmd_done, cmd_abort, erase_start, wear_level_start}));
////////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
        errors++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
endtask
// Loads control word and password, issues the opcode, checks its events
task automatic cmd(input logic [7:0] op, input logic [15:0] cw, input logic [7:0] s, input logic [3:0] x);
    host.wr(OFF_CTRLW, {16'h0000, cw}, ev);
    for (int i = 0; i < PW_WORDS; i++) host.wr(OFF_PW0 + 8'(4 * i), {s, 24'(i)}, ev);
    host.wr(OFF_CMD, {24'h000000, op}, ev);
    chk({28'h0000000, ev}, {28'h0000000, x});
endtask
// Status: frozen, locked, enabled and try counter; err is judged by events
task automatic st(input logic [31:0] x);
    host.rd(OFF_STATUS, rv, rr);
    chk(rv & 32'h0000071C, x);
endtask
task automatic results();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
    clk = 1'b0;
    forever #20 clk = ~clk;
end
// Whole run is near 1000 cycles; this leaves a wide margin
initial
begin
    #500000;
    errors++;
    results();
end
initial
begin
    errors = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    st(32'h00000500);
    host.rd(OFF_IDENT, rv, rr);
    chk(rv, 32'h00000021);
    host.rd(8'hFC, rv, rr);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    host.wr(8'hFC, 32'h0, ev);
    chk({30'h0, host.br}, {30'h0, RESP_SLVERR});
    cmd(OP_SET_PW, 16'h0000, 8'hA1, 4'h8);
    cmd(OP_SET_PW, 16'h0001, 8'hB2, 4'h8);
    st(32'h00000510);
    cmd(OP_UNLOCK, 16'h0000, 8'h33, 4'hC);
    st(32'h00000510);
    host.wr(OFF_HWRST, 32'h0, ev);
    st(32'h00000518);
    for (int k = 4; k >= 0; k--)
    begin
        cmd(OP_UNLOCK, 16'h0000, 8'h33, 4'hC);
        st({21'h0, 3'(k), 8'h18});
    end
    cmd(OP_UNLOCK, 16'h0000, 8'hA1, 4'hC);
    cmd(OP_PREPARE, 16'h0000, 8'h00, 4'h8);
    cmd(OP_ERASE, 16'h0000, 8'hA1, 4'hC);
    st(32'h00000018);
    host.wr(OFF_HWRST, 32'h0, ev);
    cmd(OP_ERASE, 16'h0000, 8'hA1, 4'hC);
    cmd(OP_PREPARE, 16'h0000, 8'h00, 4'h8);
    cmd(OP_ERASE, 16'h0000, 8'h33, 4'hC);
    cmd(OP_PREPARE, 16'h0000, 8'h00, 4'h8);
    cmd(OP_ERASE, 16'h0000, 8'hA1, 4'hA);
    st(32'h00000500);
    cmd(OP_SET_PW, 16'h0100, 8'hC3, 4'h8);
    host.wr(OFF_HWRST, 32'h0, ev);
    st(32'h00000518);
    cmd(OP_UNLOCK, 16'h0001, 8'hB2, 4'hC);
    st(32'h00000518);
    chk(rv & 32'h3, 32'h3);
    cmd(OP_DISABLE, 16'h0000, 8'hC3, 4'h8);
    st(32'h00000500);
    chk(rv & 32'h3, 32'h1);
    cmd(OP_SET_PW, 16'h0000, 8'hA1, 4'h8);
    host.wr(OFF_HWRST, 32'h0, ev);
    cmd(OP_UNLOCK, 16'h0000, 8'hA1, 4'h8);
    host.wr(OFF_HWRST, 32'h0, ev);
    cmd(OP_UNLOCK, 16'h0001, 8'hB2, 4'h8);
    st(32'h00000510);
    host.wr(OFF_SECCNT, 32'h000000AB, ev);
    chk({30'h0, host.br}, {30'h0, RESP_OKAY});
    cmd(OP_FREEZE, 16'h0000, 8'h00, 4'h8);
    host.rd(OFF_SECCNT, rv, rr);
    chk(rv, 32'h00000000);
    cmd(OP_PREPARE, 16'h0000, 8'h00, 4'h8);
    foreach (ops[i]) cmd(ops[i], 16'h0000, 8'hA1, 4'hC);
    st(32'h00000514);
    cmd(OP_FREEZE, 16'h0000, 8'h00, 4'h8);
    st(32'h00000514);
    host.wr(OFF_HWRST, 32'h0, ev);
    st(32'h00000518);
    host.wr(OFF_CONFIG, 32'h0, ev);
    cmd(OP_FREEZE, 16'h0000, 8'h00, 4'h9);
    results();
end
endmodule
`default_nettype wire
